// >>> hdl/pjdd_decoder.sv
// Positioning job data decoder top
`timescale 1ns/1ps
module pjdd_decoder
	import pjdd_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Job request
	input  wire logic        job_valid,
	output logic             job_ready,
	input  wire logic [7:0]  job_code,
	input  wire logic [15:0] job_word_n4,
	input  wire logic [15:0] job_word_n5,
	input  wire logic [15:0] job_word_n6,
	input  wire logic [15:0] job_word_n7,
	input  wire logic [15:0] job_word_n11,
	input  wire logic [15:0] job_word_n12,
	input  wire logic [15:0] job_word_n13,
	input  wire logic [15:0] job_word_n14,
	// Machine configuration
	input  wire logic        bcd_coding,
	input  wire logic        rotary_axis,
	// Decoded job
	output logic             dec_valid,
	output logic             param_err,
	output logic             speed_rapid,
	output logic             dir_fwd,
	output logic             dir_rev,
	output logic             shortest_path,
	output logic             no_target,
	output logic             clear_rev_cnt,
	output logic [31:0]      target_value,
	output logic [1:0]       exec_mode,
	output logic [31:0]      compare_value,
	output logic [7:0]       target_set_num,
	output logic [7:0]       adapt_factor
);
	//==================================================================
	// Converter
	pjdd_conv_if cif ();
	pjdd_bcd_conv #(.DIGITS(PJDD_BCD_DIGITS)) u_conv (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.cif     (cif.conv)
	);

	//==================================================================
	// State
	pjdd_state_e  st_r, st_nxt;        // Sequencer
	logic         start_r, start_nxt;  // Converter kick
	logic         sel_r, sel_nxt;      // 1: convert comparison
	logic         relneg_r, relneg_nxt;// Path sign from direction
	logic [47:0]  val_w_r, val_w_nxt;  // Value words
	logic [47:0]  cmp_w_r, cmp_w_nxt;  // Comparison words
	logic         err_r, err_nxt;      // Parameter error
	logic         rapid_r, rapid_nxt;
	logic         fwd_r, fwd_nxt;
	logic         rev_r, rev_nxt;
	logic         short_r, short_nxt;
	logic         notgt_r, notgt_nxt;
	logic         clr_r, clr_nxt;      // Clear revolution request
	logic [31:0]  tgt_r, tgt_nxt;
	logic [1:0]   exec_r, exec_nxt;
	logic [31:0]  cmp_r, cmp_nxt;
	logic [7:0]   tset_r, tset_nxt;
	logic [7:0]   adapt_r, adapt_nxt;

	//==================================================================
	// Which fields each job actually uses
	logic accept;    // Job taken this cycle
	logic spd_use;   // Speed selector meaningful
	logic dir_use;   // Direction byte meaningful
	logic val_use;   // Value and execution fields meaningful
	logic rel_kind;  // Value is unsigned path length
	logic known;     // Job code decoded here
	logic [7:0] lo;  // Low byte of first word
	logic no_dir;    // Neither direction requested

	assign accept  = job_valid && st_r == PJDD_IDLE;
	assign lo      = job_word_n4[7:0];
	assign no_dir  = !job_word_n4[PJDD_BIT_FWD]
		&& !job_word_n4[PJDD_BIT_REV];
	// Jog, reference, absolute, relative use speed; set actual, set zero, offset leave it reserved
	assign spd_use = job_code == PJDD_JOB_JOG || job_code == PJDD_JOB_REF
		|| job_code == PJDD_JOB_ABS || job_code == PJDD_JOB_REL;
	// Jog, set actual, set zero leave the bit byte reserved
	assign dir_use = job_code == PJDD_JOB_REF || job_code == PJDD_JOB_ABS
		|| job_code == PJDD_JOB_REL || job_code == PJDD_JOB_ZOFF;
	assign val_use = job_code == PJDD_JOB_ABS || job_code == PJDD_JOB_REL
		|| job_code == PJDD_JOB_SETACT || job_code == PJDD_JOB_SETZERO
		|| job_code == PJDD_JOB_ZOFF;
	assign rel_kind = job_code == PJDD_JOB_REL
		|| job_code == PJDD_JOB_ZOFF;
	assign known   = spd_use || val_use || job_code == PJDD_JOB_TSET
		|| job_code == PJDD_JOB_ADAPT;

	assign job_ready     = st_r == PJDD_IDLE;
	assign dec_valid     = st_r == PJDD_DONE;
	assign clear_rev_cnt = dec_valid && clr_r;
	assign param_err     = err_r;
	assign speed_rapid   = rapid_r;
	assign dir_fwd       = fwd_r;
	assign dir_rev       = rev_r;
	assign shortest_path = short_r;
	assign no_target     = notgt_r;
	assign target_value  = tgt_r;
	assign exec_mode     = exec_r;
	assign compare_value = cmp_r;
	assign target_set_num = tset_r;
	assign adapt_factor  = adapt_r;

	assign cif.start = start_r;
	assign cif.bcd   = bcd_coding;
	assign cif.w_hi  = sel_r ? cmp_w_r[47:32] : val_w_r[47:32];
	assign cif.w_mid = sel_r ? cmp_w_r[31:16] : val_w_r[31:16];
	assign cif.w_lo  = sel_r ? cmp_w_r[15:0]  : val_w_r[15:0];

	//==================================================================
	// Next state; results hold until the next job is taken
	always_comb begin
		st_nxt     = st_r;
		start_nxt  = 1'b0;
		sel_nxt    = sel_r;
		relneg_nxt = relneg_r;
		val_w_nxt  = val_w_r;
		cmp_w_nxt  = cmp_w_r;
		err_nxt    = err_r;
		rapid_nxt  = rapid_r;
		fwd_nxt    = fwd_r;
		rev_nxt    = rev_r;
		short_nxt  = short_r;
		notgt_nxt  = notgt_r;
		clr_nxt    = clr_r;
		tgt_nxt    = tgt_r;
		exec_nxt   = exec_r;
		cmp_nxt    = cmp_r;
		tset_nxt   = tset_r;
		adapt_nxt  = adapt_r;
		unique case (st_r)
			PJDD_IDLE: begin
				if (accept) begin
					val_w_nxt = {job_word_n5, job_word_n6, job_word_n7};
					cmp_w_nxt = {job_word_n12, job_word_n13, job_word_n14};
					err_nxt   = !known;
					tgt_nxt   = 32'h0;
					cmp_nxt   = 32'h0;
					exec_nxt  = 2'b00;
					tset_nxt  = 8'h00;
					adapt_nxt = 8'h00;
					rapid_nxt = 1'b0;
					// Speed: creep or rapid, anything else refused
					if (spd_use) begin
						rapid_nxt = lo == PJDD_SPEED_RAPID;
						if (lo != PJDD_SPEED_RAPID && lo != PJDD_SPEED_CREEP)
							err_nxt = 1'b1;
					end
					// Directions; target set only when rotary
					if (dir_use ||
						(job_code == PJDD_JOB_TSET && rotary_axis)) begin
						fwd_nxt   = job_word_n4[PJDD_BIT_FWD];
						rev_nxt   = job_word_n4[PJDD_BIT_REV];
						short_nxt = rotary_axis && no_dir;
					end else begin
						fwd_nxt   = 1'b0;
						rev_nxt   = 1'b0;
						short_nxt = 1'b0;
					end
					// Target set ignores bits 10 to 15
					notgt_nxt  = dir_use && job_word_n4[PJDD_BIT_NOTGT];
					clr_nxt    = dir_use && job_word_n4[PJDD_BIT_CLRREV];
					relneg_nxt = rel_kind && job_word_n4[PJDD_BIT_REV];
					if (job_code == PJDD_JOB_TSET) begin
						tset_nxt = lo;
						if (lo < PJDD_TSET_MIN)
							err_nxt = 1'b1;
					end
					if (job_code == PJDD_JOB_ADAPT) begin
						adapt_nxt = lo;
						if (lo < PJDD_ADAPT_MIN || lo > PJDD_ADAPT_MAX)
							err_nxt = 1'b1;
					end
					if (val_use) begin
						exec_nxt = job_word_n11[1:0];
						if (job_word_n11 != PJDD_EXEC_NOW &&
							job_word_n11 != PJDD_EXEC_EVENT &&
							job_word_n11 != PJDD_EXEC_POS)
							err_nxt = 1'b1;
						sel_nxt   = 1'b0;
						start_nxt = 1'b1;
						st_nxt    = PJDD_VAL;
					end else begin
						st_nxt = PJDD_DONE;
					end
				end
			end
			PJDD_VAL: begin
				if (cif.done) begin
					err_nxt = err_r || cif.err;
					tgt_nxt = relneg_r ? 32'(-cif.value) : cif.value;
					// Position trigger needs its own conversion
					if (exec_r == PJDD_EXEC_POS[1:0]) begin
						sel_nxt   = 1'b1;
						start_nxt = 1'b1;
						st_nxt    = PJDD_CMP;
					end else begin
						st_nxt = PJDD_DONE;
					end
				end
			end
			PJDD_CMP: begin
				if (cif.done) begin
					err_nxt = err_r || cif.err;
					cmp_nxt = cif.value;
					st_nxt  = PJDD_DONE;
				end
			end
			PJDD_DONE: begin
				st_nxt = PJDD_IDLE;
			end
		endcase
	end

	//==================================================================
	// Registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			st_r     <= PJDD_IDLE;
			start_r  <= 1'b0;
			sel_r    <= 1'b0;
			relneg_r <= 1'b0;
			val_w_r  <= 48'h0;
			cmp_w_r  <= 48'h0;
			err_r    <= 1'b0;
			rapid_r  <= 1'b0;
			fwd_r    <= 1'b0;
			rev_r    <= 1'b0;
			short_r  <= 1'b0;
			notgt_r  <= 1'b0;
			clr_r    <= 1'b0;
			tgt_r    <= 32'h0;
			exec_r   <= 2'b00;
			cmp_r    <= 32'h0;
			tset_r   <= 8'h00;
			adapt_r  <= 8'h00;
		end else begin
			st_r     <= st_nxt;
			start_r  <= start_nxt;
			sel_r    <= sel_nxt;
			relneg_r <= relneg_nxt;
			val_w_r  <= val_w_nxt;
			cmp_w_r  <= cmp_w_nxt;
			err_r    <= err_nxt;
			rapid_r  <= rapid_nxt;
			fwd_r    <= fwd_nxt;
			rev_r    <= rev_nxt;
			short_r  <= short_nxt;
			notgt_r  <= notgt_nxt;
			clr_r    <= clr_nxt;
			tgt_r    <= tgt_nxt;
			exec_r   <= exec_nxt;
			cmp_r    <= cmp_nxt;
			tset_r   <= tset_nxt;
			adapt_r  <= adapt_nxt;
		end
	end

	//==================================================================
	// Checks
	a_speed_rapid: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && spd_use && lo == 8'h01 |=> speed_rapid)
		else $error("rapid selector not decoded");
	a_dir_fwd: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && dir_use |=> dir_fwd == $past(job_word_n4[8]))
		else $error("forward bit not decoded");
	a_dir_rev: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && dir_use |=> dir_rev == $past(job_word_n4[9]))
		else $error("reverse bit not decoded");
	a_short_path: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && dir_use && rotary_axis && job_word_n4[9:8] == 2'b00
		|=> shortest_path)
		else $error("shortest path not chosen");
	a_no_target: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && dir_use |=> no_target == $past(job_word_n4[10]))
		else $error("no-target bit not decoded");
	a_clear_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && !val_use && dir_use && job_word_n4[PJDD_BIT_CLRREV]
		|-> ##1 clear_rev_cnt ##1 !clear_rev_cnt)
		else $error("revolution clear pulse wrong");
	a_tset_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && job_code == PJDD_JOB_TSET && lo < PJDD_TSET_MIN
		|-> ##1 (dec_valid && param_err))
		else $error("target set zero not refused");
	a_adapt_range: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && job_code == PJDD_JOB_ADAPT
		|-> ##1 (dec_valid && param_err == ($past(lo) < PJDD_ADAPT_MIN
		|| $past(lo) > PJDD_ADAPT_MAX)))
		else $error("adaption range check wrong");
	a_tset_ignore: assert property (@(posedge sys_clk) disable iff (!resetn)
		accept && job_code == 8'h05 |=> !no_target && !clear_rev_cnt
		&& (rotary_axis || (!dir_fwd && !dir_rev)))
		else $error("target set bits not masked");
endmodule

// >>> common/pjdd_pkg.sv
// Constants and types for the positioning job data decoder
//==================================================================
package pjdd_pkg;
	//==================================================================
	// Job codes
	localparam logic [7:0] PJDD_JOB_JOG     = 8'h01;
	localparam logic [7:0] PJDD_JOB_REF     = 8'h02;
	localparam logic [7:0] PJDD_JOB_ABS     = 8'h03;
	localparam logic [7:0] PJDD_JOB_REL     = 8'h04;
	localparam logic [7:0] PJDD_JOB_TSET    = 8'h05;
	localparam logic [7:0] PJDD_JOB_SETACT  = 8'h10;
	localparam logic [7:0] PJDD_JOB_SETZERO = 8'h11;
	localparam logic [7:0] PJDD_JOB_ZOFF    = 8'h12;
	localparam logic [7:0] PJDD_JOB_ADAPT   = 8'h14;
	//==================================================================
	// Bit parameter positions in the first job word
	localparam int PJDD_BIT_FWD    = 8;
	localparam int PJDD_BIT_REV    = 9;
	localparam int PJDD_BIT_NOTGT  = 10;
	localparam int PJDD_BIT_CLRREV = 12;
	//==================================================================
	// Field values
	localparam logic [7:0]  PJDD_SPEED_CREEP = 8'h00;
	localparam logic [7:0]  PJDD_SPEED_RAPID = 8'h01;
	localparam int          PJDD_SIGN_LSB    = 8;
	localparam logic [3:0]  PJDD_SIGN_POS    = 4'h0;
	localparam logic [3:0]  PJDD_SIGN_NEG    = 4'hF;
	localparam logic [3:0]  PJDD_DIGIT_MAX   = 4'h9;
	localparam logic [15:0] PJDD_EXEC_NOW    = 16'h0000;
	localparam logic [15:0] PJDD_EXEC_EVENT  = 16'h0001;
	localparam logic [15:0] PJDD_EXEC_POS    = 16'h0002;
	localparam logic [7:0]  PJDD_TSET_MIN    = 8'h01;
	localparam logic [7:0]  PJDD_ADAPT_MIN   = 8'h01;
	localparam logic [7:0]  PJDD_ADAPT_MAX   = 8'h64;
	localparam int          PJDD_BCD_DIGITS  = 10;
	//==================================================================
	// Decoder states, Gray along idle-value-compare-done
	typedef enum logic [1:0] {
		PJDD_IDLE = 2'b00,
		PJDD_VAL  = 2'b01,
		PJDD_CMP  = 2'b11,
		PJDD_DONE = 2'b10
	} pjdd_state_e;
endpackage

// >>> common/pjdd_conv_if.sv
// Carrier between the decoder and its value converter
`timescale 1ns/1ps
interface pjdd_conv_if;
	logic        start;  // One-cycle conversion request
	logic        bcd;    // Coding: 1 BCD, 0 binary
	logic [15:0] w_hi;   // Sign and top digits
	logic [15:0] w_mid;  // Middle word
	logic [15:0] w_lo;   // Low word
	logic        busy;   // BCD walk in progress
	logic        done;   // One-cycle result strobe
	logic        err;    // Bad coding or overflow
	logic [31:0] value;  // Signed result
	modport conv (input start, bcd, w_hi, w_mid, w_lo,
		output busy, done, err, value);
	modport user (output start, bcd, w_hi, w_mid, w_lo,
		input busy, done, err, value);
endinterface

// >>> hdl/pjdd_bcd_conv.sv
// Value converter: binary pass-through or BCD to two's complement
`timescale 1ns/1ps
module pjdd_bcd_conv
	import pjdd_pkg::*;
#(
	parameter int DIGITS = PJDD_BCD_DIGITS  // BCD digits per value
) (
	// Clock and reset
	input  wire logic    sys_clk,
	input  wire logic    resetn,
	// Decoder side
	pjdd_conv_if.conv    cif
);
	// Three-word layout carries exactly ten digits
	if (DIGITS != PJDD_BCD_DIGITS) begin : g_chk
		$error("pjdd_bcd_conv: DIGITS must be ten");
	end

	//==================================================================
	// State
	logic                  busy_r, busy_nxt;   // Walking digits
	logic                  done_r, done_nxt;   // Result strobe
	logic                  err_r, err_nxt;     // Sticky per value
	logic                  neg_r, neg_nxt;     // Sign nibble negative
	logic [3:0]            cnt_r, cnt_nxt;     // Digits left
	logic [4*DIGITS-1:0]   dig_r, dig_nxt;     // Digits, MSD first
	logic [33:0]           acc_r, acc_nxt;     // Magnitude so far
	logic [31:0]           val_r, val_nxt;     // Result

	assign cif.busy  = busy_r;
	assign cif.done  = done_r;
	assign cif.err   = err_r;
	assign cif.value = val_r;

	//==================================================================
	// One digit per cycle keeps the multiply short at 250 MHz
	always_comb begin
		logic [3:0]  d;
		logic [33:0] sum;
		d        = dig_r[4*DIGITS-1 -: 4];
		sum      = {acc_r[30:0], 3'b000} + {acc_r[32:0], 1'b0}
			+ {30'h0, d};
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		err_nxt  = err_r;
		neg_nxt  = neg_r;
		cnt_nxt  = cnt_r;
		dig_nxt  = dig_r;
		acc_nxt  = acc_r;
		val_nxt  = val_r;
		if (cif.start && !busy_r) begin
			if (!cif.bcd) begin
				// Binary: high word reserved, two low words verbatim
				val_nxt  = {cif.w_mid, cif.w_lo};
				err_nxt  = 1'b0;
				done_nxt = 1'b1;
			end else begin
				neg_nxt = cif.w_hi[PJDD_SIGN_LSB +: 4] == PJDD_SIGN_NEG;
				err_nxt = cif.w_hi[PJDD_SIGN_LSB +: 4] != PJDD_SIGN_POS
					&& cif.w_hi[PJDD_SIGN_LSB +: 4] != PJDD_SIGN_NEG;
				dig_nxt  = {cif.w_hi[7:0], cif.w_mid, cif.w_lo};
				acc_nxt  = 34'h0;
				cnt_nxt  = 4'(DIGITS);
				busy_nxt = 1'b1;
			end
		end else if (busy_r) begin
			// Non-decimal digit poisons the value
			if (d > PJDD_DIGIT_MAX)
				err_nxt = 1'b1;
			acc_nxt = sum;
			dig_nxt = {dig_r[4*DIGITS-5:0], 4'h0};
			cnt_nxt = cnt_r - 4'h1;
			if (cnt_r == 4'h1) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				val_nxt  = neg_r ? 32'(-sum) : sum[31:0];
				// Ten digits can exceed 32 bits
				if (sum[33:32] != 2'b00 ||
					(sum[31] && !(neg_r && sum[30:0] == 31'h0)))
					err_nxt = 1'b1;
			end
		end
	end

	//==================================================================
	// Registers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			err_r  <= 1'b0;
			neg_r  <= 1'b0;
			cnt_r  <= 4'h0;
			dig_r  <= '0;
			acc_r  <= 34'h0;
			val_r  <= 32'h0;
		end else begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			err_r  <= err_nxt;
			neg_r  <= neg_nxt;
			cnt_r  <= cnt_nxt;
			dig_r  <= dig_nxt;
			acc_r  <= acc_nxt;
			val_r  <= val_nxt;
		end
	end

	//==================================================================
	// Checks
	a_binary_pass: assert property (@(posedge sys_clk) disable iff (!resetn)
		cif.start && !busy_r && !cif.bcd |=> done_r
		&& val_r == {$past(cif.w_mid), $past(cif.w_lo)})
		else $error("binary value not passed through");
	a_sign_err: assert property (@(posedge sys_clk) disable iff (!resetn)
		cif.start && !busy_r && cif.bcd
		&& cif.w_hi[11:8] != 4'h0 && cif.w_hi[11:8] != 4'hF
		|-> ##11 (done_r && err_r))
		else $error("bad sign nibble not flagged");
endmodule

// >>> testbench/pjdd_host_model.sv
// Model of the controlling program that fills the job data words
`timescale 1ns/1ps
module pjdd_host_model
	import pjdd_pkg::*;
(
	// Clock and handshake
	input  wire logic        sys_clk,
	input  wire logic        job_ready,
	output logic             job_valid,
	// Job data: n4,n5,n6,n7,n11,n12,n13,n14 from the top down
	output logic [7:0]       job_code,
	output logic [127:0]     words
);
	//==================================================================
	// Idle lines at time zero
	initial begin
		job_valid = 1'h0;
		job_code  = 8'h00;
		words     = 128'h0;
	end

	//==================================================================
	// One job: raise, hold until taken, then release
	task automatic offer(input logic [7:0] code, input logic [127:0] wd);
		logic [127:0] m;
		m = wd;
		// Direction byte left clear where it is reserved
		if (code == PJDD_JOB_JOG || code == PJDD_JOB_SETACT ||
			code == PJDD_JOB_SETZERO) begin
			m[127:120] = 8'h00;
		end
		// Speed byte left clear where it is reserved
		if (code == PJDD_JOB_SETACT || code == PJDD_JOB_SETZERO ||
			code == PJDD_JOB_ZOFF) begin
			m[119:112] = 8'h00;
		end
		@(posedge sys_clk);
		job_valid <= 1'h1;
		job_code  <= code;
		words     <= m;
		// Ready is combinational, so look at it mid-cycle
		do @(negedge sys_clk); while (job_ready !== 1'h1);
		@(posedge sys_clk);
		// Released lines show the inverse, so stale data cannot pass
		job_valid <= 1'h0;
		job_code  <= ~code;
		words     <= ~m;
	endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the positioning job data decoder
`timescale 1ns/1ps
module testbench;
	import pjdd_pkg::*;
	//==================================================================
	// Ordinary case: job words beside the outputs they should give
	typedef struct packed {
		logic [7:0]   code;
		logic [127:0] wd;   // n4,n5,n6,n7,n11,n12,n13,n14
		logic         bcd;
		logic         rot;
		logic [5:0]   fl;   // rapid,fwd,rev,shortest,no target,clear
		logic [31:0]  tgt;
		logic [1:0]   ex;
		logic [31:0]  cmp;
		logic [7:0]   ts;
		logic [7:0]   ad;
	} pjdd_row_s;

	logic         sys_clk;        // 250 MHz clock
	logic         resetn;         // Synchronous reset
	logic         bcd_coding;     // Value coding setting
	logic         rotary_axis;    // Axis kind setting
	logic         job_valid;      // From the host model
	logic [7:0]   job_code;       // From the host model
	logic [127:0] words;          // From the host model
	logic         job_ready, dec_valid, param_err, speed_rapid;
	logic         dir_fwd, dir_rev, shortest_path, no_target;
	logic         clear_rev_cnt;  // One-cycle pulse
	logic [31:0]  target_value;   // Decoded value
	logic [1:0]   exec_mode;      // Execution selector
	logic [31:0]  compare_value;  // Trigger position
	logic [7:0]   target_set_num; // Target set number
	logic [7:0]   adapt_factor;   // Adaption factor
	pjdd_row_s    rows [12];      // Ordinary cases
	int           errors;         // Mismatches
	int           tests_run;      // Comparisons
	int           seen;           // Stray completions

	//==================================================================
	// Design and far side
	pjdd_decoder DUT (.sys_clk(sys_clk), .resetn(resetn),
		.job_valid(job_valid), .job_ready(job_ready), .job_code(job_code),
		.job_word_n4(words[127:112]), .job_word_n5(words[111:96]),
		.job_word_n6(words[95:80]), .job_word_n7(words[79:64]),
		.job_word_n11(words[63:48]), .job_word_n12(words[47:32]),
		.job_word_n13(words[31:16]), .job_word_n14(words[15:0]),
		.bcd_coding(bcd_coding), .rotary_axis(rotary_axis),
		.dec_valid(dec_valid), .param_err(param_err),
		.speed_rapid(speed_rapid), .dir_fwd(dir_fwd), .dir_rev(dir_rev),
		.shortest_path(shortest_path), .no_target(no_target),
		.clear_rev_cnt(clear_rev_cnt), .target_value(target_value),
		.exec_mode(exec_mode), .compare_value(compare_value),
		.target_set_num(target_set_num), .adapt_factor(adapt_factor));
	pjdd_host_model host (.sys_clk(sys_clk), .job_ready(job_ready),
		.job_valid(job_valid), .job_code(job_code), .words(words));

	//==================================================================
	// Clock and watchdog, sized well above the expected run
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		#20000;
		errors++;
		$display("ERROR watchdog expected finish seen hang");
		end_sim();
	end

	//==================================================================
	// Compare tasks, one per kind of result
	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bounded wait for the completion pulse, left at its cycle
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (dec_valid !== 1'h1 && n < 60);
		chk_bit("dec_valid", 1'h1, dec_valid);
	endtask

	// Settings change on a rising edge, then the job goes out
	task automatic send(input logic [7:0] c, input logic [127:0] w,
		input logic b, input logic r);
		@(posedge sys_clk);
		bcd_coding  <= b;
		rotary_axis <= r;
		host.offer(c, w);
		wait_done();
	endtask

	task automatic run_row(input int i);
		pjdd_row_s r;
		r = rows[i];
		send(r.code, r.wd, r.bcd, r.rot);
		chk_bit("param_err", 1'h0, param_err);
		chk_bit("speed_rapid", r.fl[5], speed_rapid);
		chk_bit("dir_fwd", r.fl[4], dir_fwd);
		chk_bit("dir_rev", r.fl[3], dir_rev);
		chk_bit("shortest", r.fl[2], shortest_path);
		chk_bit("no_target", r.fl[1], no_target);
		chk_bit("clear_rev", r.fl[0], clear_rev_cnt);
		chk_val("target", r.tgt, target_value);
		chk_val("exec", {30'h0, r.ex}, {30'h0, exec_mode});
		chk_val("compare", r.cmp, compare_value);
		chk_val("tset", {24'h0, r.ts}, {24'h0, target_set_num});
		chk_val("adapt", {24'h0, r.ad}, {24'h0, adapt_factor});
	endtask

	// Job that must finish with the parameter error raised
	task automatic expect_err(input logic [7:0] c, input logic [15:0] n4,
		input logic [15:0] n5, input logic [15:0] n7,
		input logic [15:0] n11, input logic b);
		send(c, {n4, n5, 16'h0000, n7, n11, 48'h0}, b, 1'h0);
		chk_bit("param_err", 1'h1, param_err);
	endtask

	task automatic end_sim();
		$display("Checks run %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	//==================================================================
	// Main sequence
	initial begin
		errors      = 0;
		tests_run   = 0;
		resetn      = 1'h0;
		bcd_coding  = 1'h0;
		rotary_axis = 1'h0;
		rows[0] = '{8'h03, 128'hE901_0000_FFFF_FF85_0002_0000_0000_0100,
			1'h0, 1'h0, 6'h30, 32'hFFFFFF85, 2'h2, 32'h00000100, 8'h00, 8'h00};
		rows[1] = '{8'h03, 128'h0000_0F01_2345_6789_0002_0000_0000_0042,
			1'h1, 1'h1, 6'h04, 32'hF8A432EB, 2'h2, 32'h0000002A, 8'h00, 8'h00};
		rows[2] = '{8'h04, 128'h0201_0000_0000_03E8_0001_0000_0000_0000,
			1'h0, 1'h0, 6'h28, 32'hFFFFFC18, 2'h1, 32'h00000000, 8'h00, 8'h00};
		rows[3] = '{8'h12, 128'h0100_0000_0000_0500_0000_0000_0000_0000,
			1'h1, 1'h0, 6'h10, 32'h000001F4, 2'h0, 32'h00000000, 8'h00, 8'h00};
		rows[4] = '{8'h10, 128'h0000_0000_1234_5678_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h00, 32'h12345678, 2'h0, 32'h00000000, 8'h00, 8'h00};
		rows[5] = '{8'h11, 128'h0000_0F00_0000_0007_0000_0000_0000_0000,
			1'h1, 1'h0, 6'h00, 32'hFFFFFFF9, 2'h0, 32'h00000000, 8'h00, 8'h00};
		rows[6] = '{8'h01, 128'h0001_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h20, 32'h00000000, 2'h0, 32'h00000000, 8'h00, 8'h00};
		rows[7] = '{8'h02, 128'h1600_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h0B, 32'h00000000, 2'h0, 32'h00000000, 8'h00, 8'h00};
		rows[8] = '{8'h05, 128'h00FF_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h1, 6'h04, 32'h00000000, 2'h0, 32'h00000000, 8'hFF, 8'h00};
		rows[9] = '{8'h05, 128'hFD05_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h00, 32'h00000000, 2'h0, 32'h00000000, 8'h05, 8'h00};
		rows[10] = '{8'h14, 128'h0064_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h00, 32'h00000000, 2'h0, 32'h00000000, 8'h00, 8'h64};
		rows[11] = '{8'h14, 128'h0001_0000_0000_0000_0000_0000_0000_0000,
			1'h0, 1'h0, 6'h00, 32'h00000000, 2'h0, 32'h00000000, 8'h00, 8'h01};
		// Outputs while reset is held
		repeat (10) @(negedge sys_clk);
		chk_bit("ready_in_reset", 1'h1, job_ready);
		chk_bit("done_in_reset", 1'h0, dec_valid);
		chk_val("target_in_reset", 32'h0, target_value);
		repeat (10) @(posedge sys_clk);
		resetn <= 1'h1;
		// Ordinary cases
		for (int i = 0; i < 12; i++) begin
			run_row(i);
		end
		// Refused values, each still completes
		expect_err(8'h14, 16'h0000, 16'h0, 16'h0, 16'h0, 1'h0);
		expect_err(8'h14, 16'h0065, 16'h0, 16'h0, 16'h0, 1'h0);
		expect_err(8'h05, 16'h0000, 16'h0, 16'h0, 16'h0, 1'h0);
		expect_err(8'h03, 16'h0000, 16'h0, 16'h000A, 16'h0, 1'h1);
		expect_err(8'h03, 16'h0000, 16'h0500, 16'h1, 16'h0, 1'h1);
		expect_err(8'h03, 16'h0000, 16'h0, 16'h1, 16'h3, 1'h0);
		expect_err(8'h06, 16'h0000, 16'h0, 16'h0, 16'h0, 1'h0);
		expect_err(8'h03, 16'h0002, 16'h0, 16'h0, 16'h0, 1'h0);
		// Next good job clears the error flag
		run_row(0);
		// Reset in mid conversion drops the job
		send_abort();
		end_sim();
	end

	task automatic send_abort();
		@(posedge sys_clk);
		bcd_coding <= 1'h1;
		host.offer(8'h03, 128'h0000_0F09_9999_9999_0000_0000_0000_0000);
		repeat (2) @(posedge sys_clk);
		resetn <= 1'h0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'h1;
		seen = 0;
		repeat (40) begin
			@(negedge sys_clk);
			seen += (dec_valid === 1'h1) ? 1 : 0;
		end
		chk_val("late_done", 32'h0, seen);
		chk_val("target_after_reset", 32'h0, target_value);
		chk_bit("ready_after_reset", 1'h1, job_ready);
	endtask
endmodule
